// ===== dv/fpm_src.sv
// partner model: external trigger and +-5 v modulation sources
// assumes the bench calls its tasks and shares the block clock
module fpm_src
(
    input wire logic clock,
    output logic trig_in,
    output logic signed [11:0] ext_mod
);
    timeunit 1ns;
    timeprecision 1ps;
    realtime last_t = -1.0e4;
    initial
    begin
        trig_in = 1'b0;
        ext_mod = 12'sh000;
    end
    task automatic set_trig(input logic v);
        @(posedge clock);
        while ($realtime - last_t < 5000.0)
            @(posedge clock);
        trig_in <= v;
        last_t = $realtime;
    endtask
    task automatic set_mod(input logic signed [11:0] v);
        @(posedge clock);
        ext_mod <= v;
    endtask
endmodule

// ===== dv/tb.sv
// self-checking bench for the fsk / pwm control block
// assumes fpm_ctrl, its package and the fpm_src partner model
module tb import fpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic trig_in;
    logic signed [11:0] ext_mod;
    fpm_out_s mod_out;
    logic [11:0] arb_addr;
    logic [31:0] rd;
    int failures = 0;
    int checks = 0;
    // ****************************************
    // block and partner
    // ****************************************
    fpm_ctrl dut_u (.clock(clock), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .trig_in(trig_in), .ext_mod(ext_mod),
        .mod_out(mod_out), .arb_addr(arb_addr));
    fpm_src src_u (.clock(clock), .trig_in(trig_in), .ext_mod(ext_mod));
    initial
    begin
        forever #2 clock = ~clock;
    end
    // ****************************************
    // helpers
    // ****************************************
    task automatic summarize();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // a used-up wait counts as a mismatch and ends the run
    task automatic tmo(input logic hit, input string m);
        if (hit)
        begin
            cmp(32'h1, 32'h0, m);
            summarize();
        end
    endtask
    // bus request held until waitrequest seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        avs_byteenable <= 4'hf;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        tmo(n >= 50, "bus timeout");
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input string m);
        bus(1'b0, a, 32'h0);
        cmp(rd, e, m);
    endtask
    task automatic wrchk(input logic [3:0] a, input logic [31:0] d, input logic [31:0] e);
        bus(1'b1, a, d);
        rdchk(a, e, "readback");
    endtask
    // hop must settle within 4 cycles, then hold
    task automatic hop_is(input logic e);
        repeat (4) @(posedge clock);
        repeat (1500)
        begin
            @(posedge clock);
            if (mod_out.hop !== e)
                break;
        end
        cmp({31'h0, mod_out.hop}, {31'h0, e}, "hop level");
    endtask
    task automatic on_is(input logic e);
        repeat (4) @(posedge clock);
        cmp({31'h0, mod_out.pwm_on}, {31'h0, e}, "pwm on");
    endtask
    task automatic lvl(input logic l, output int k);
        k = 0;
        while (mod_out.pulse !== l && k < 300)
        begin
            @(posedge clock);
            k++;
        end
        tmo(k >= 300, "pulse timeout");
    endtask
    // high time of one pulse, 2 cycles of slack
    task automatic pw(input logic signed [11:0] v, input int e);
        int k;
        src_u.set_mod(v);
        repeat (600) @(posedge clock);
        lvl(1'b0, k);
        lvl(1'b1, k);
        lvl(1'b0, k);
        cmp(32'(k > e - 3 && k < e + 3), 32'h1, "pulse width");
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        rdchk(FPM_REG_CTRL, 32'h0, "ctrl");
        rdchk(FPM_REG_FSK_RATE, FPM_FSK_RATE_RST, "rate");
        rdchk(FPM_REG_PERIOD, FPM_PERIOD_RST[31:0], "period");
        rdchk(FPM_REG_MOD_FREQ, FPM_MOD_FREQ_RST, "freq");
        rdchk(FPM_REG_WDEV, FPM_WDEV_RST[31:0], "wdev");
        rdchk(FPM_REG_DDEV, {16'h0, FPM_DDEV_RST}, "ddev");
        for (int a = 10; a < 16; a++)
            wrchk(a[3:0], 32'hffff_ffff, 32'h0);
    endtask
    task automatic t_clamp();
        wrchk(FPM_REG_FSK_RATE, 32'h0, FPM_FSK_RATE_MIN);
        wrchk(FPM_REG_FSK_RATE, 32'hffff_ffff, FPM_FSK_RATE_MAX);
        wrchk(FPM_REG_MOD_FREQ, 32'h0, FPM_MOD_FREQ_MIN);
        wrchk(FPM_REG_MOD_FREQ, 32'hffff_ffff, FPM_MOD_FREQ_MAX);
        wrchk(FPM_REG_PERIOD, 32'h0, FPM_PERIOD_MIN[31:0]);
        for (int s = 0; s < 8; s++)
            wrchk(FPM_REG_CTRL, 32'(s) << 8, 32'(s == 7 ? 0 : s) << 8);
    endtask
    task automatic t_fsk();
        logic h;
        int k;
        bus(1'b1, FPM_REG_CTRL, 32'h3);
        src_u.set_trig(1'b1);
        hop_is(1'b1);
        src_u.set_trig(1'b0);
        hop_is(1'b0);
        bus(1'b1, FPM_REG_CTRL, 32'h1);
        // let the source switch settle so the first edge seen is a true toggle
        repeat (4) @(posedge clock);
        h = mod_out.hop;
        for (k = 0; k < 3000 && mod_out.hop === h; k++)
            @(posedge clock);
        tmo(k >= 3000, "fsk timeout");
        h = mod_out.hop;
        for (k = 0; k < 3000 && mod_out.hop === h; k++)
            @(posedge clock);
        cmp(32'(k > 1247 && k < 1253), 32'h1, "fsk rate");
        tmo(k >= 3000, "fsk timeout");
    endtask
    task automatic t_gate();
        bus(1'b1, FPM_REG_CTRL, 32'h4);
        on_is(1'b0);
        wrchk(FPM_REG_CTRL, 32'h4d, 32'h4c);
        on_is(1'b1);
        wrchk(FPM_REG_CTRL, 32'h5c, 32'h58);
        on_is(1'b0);
        wrchk(FPM_REG_CTRL, 32'h6c, 32'h68);
        on_is(1'b0);
    endtask
    task automatic t_dev();
        bus(1'b1, FPM_REG_PERIOD, 32'h3e8);
        bus(1'b1, FPM_REG_WIDTH, 32'h1f4);
        bus(1'b1, FPM_REG_DUTY, 32'h1388);
        bus(1'b1, FPM_REG_EDGE, 32'h5);
        wrchk(FPM_REG_WDEV, 32'h3e8, 32'h1e0);
        wrchk(FPM_REG_DDEV, 32'h2328, 32'h12c0);
        bus(1'b1, FPM_REG_EDGE, 32'h64);
        rdchk(FPM_REG_WDEV, 32'h154, "wdev edge");
        rdchk(FPM_REG_DDEV, 32'hd48, "ddev edge");
        bus(1'b1, FPM_REG_EDGE, 32'h5);
        rdchk(FPM_REG_WDEV, 32'h1e0, "wdev wmin");
    endtask
    task automatic t_ext();
        bus(1'b1, FPM_REG_CTRL, 32'h4c);
        pw(12'sh7ff, 245);
        pw(12'sh801, 5);
        pw(12'sh000, 125);
    endtask
    // 20 kHz over 4096 points: 409.6 points per 1250 cycles
    task automatic t_arb();
        logic [11:0] a0;
        a0 = arb_addr;
        repeat (1250) @(posedge clock);
        a0 = arb_addr - a0;
        cmp(32'(a0 > 12'h198 && a0 < 12'h19b), 32'h1, "arb step");
    endtask
    initial
    begin
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        t_reset();
        t_clamp();
        t_fsk();
        t_gate();
        t_dev();
        t_ext();
        t_arb();
        summarize();
    end
endmodule

// ===== logic/fpm_ctrl.sv
// fsk / pwm modulation control with avalon-mm register slave
// assumes synchronous trigger and a signed 12-bit sample of the +-5 v input
module fpm_ctrl
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic trig_in,
    input wire logic signed [11:0] ext_mod,
    output fpm_pkg::fpm_out_s mod_out,
    output logic [11:0] arb_addr
);
    import fpm_pkg::*;

    // ****************************************
    // bus slave: one wait cycle per access
    // ****************************************
    logic ack_r;
    logic wait_r;
    logic req;
    assign req = avs_read | avs_write;
    always_ff @(posedge clock)
    begin
        if (srst)
            ack_r <= 1'b0;
        else
            ack_r <= req & ~ack_r;
    end
    // registered wait: high when idle, low only in the answering cycle
    always_ff @(posedge clock)
    begin
        if (srst)
            wait_r <= 1'b1;
        else
            wait_r <= ~(req & ~ack_r);
    end
    assign avs_waitrequest = wait_r;
    logic wr;
    assign wr = avs_write & ack_r;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
        input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[i*8 +: 8] = d[i*8 +: 8];
        return r;
    endfunction

    function automatic logic [47:0] clamp(input logic [47:0] v, input logic [47:0] lo,
        input logic [47:0] hi);
        if (v < lo)
            return lo;
        else if (v > hi)
            return hi;
        else
            return v;
    endfunction

    function automatic logic [47:0] sat_sub(input logic [47:0] a, input logic [47:0] b);
        return (a > b) ? a - b : 48'h0;
    endfunction

    // ****************************************
    // settings, clamped on write except edge time
    // ****************************************
    logic [15:0] ctrl_r;
    logic [31:0] fsk_rate_r;
    logic [31:0] mod_freq_r;
    logic [47:0] period_r;
    logic [47:0] width_r;
    logic [47:0] wdev_req_r;
    logic [47:0] edge_r;
    logic [15:0] duty_r;
    logic [15:0] ddev_req_r;
    logic [31:0] wv;
    assign wv = merge(32'h0, avs_writedata, avs_byteenable);

    always_ff @(posedge clock)
    begin
        if (srst)
            ctrl_r <= 16'h0;
        else if (wr && avs_address == FPM_REG_CTRL)
        begin
            ctrl_r <= wv[15:0];
            // unknown shape codes fall back to sine
            if (wv[FPM_B_SHAPE +: 3] == 3'b111)
                ctrl_r[FPM_B_SHAPE +: 3] <= FPM_SINE;
            if (!wv[FPM_B_PULSE])
                ctrl_r[FPM_B_PWM_EN] <= 1'b0;
            // sweep or burst turns pwm and fsk off
            if (wv[FPM_B_SWEEP] | wv[FPM_B_BURST])
            begin
                ctrl_r[FPM_B_PWM_EN] <= 1'b0;
                ctrl_r[FPM_B_FSK_EN] <= 1'b0;
            end
            // fsk is not a pulse modulation
            if (wv[FPM_B_PULSE])
                ctrl_r[FPM_B_FSK_EN] <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            fsk_rate_r <= FPM_FSK_RATE_RST;
            mod_freq_r <= FPM_MOD_FREQ_RST;
            period_r <= FPM_PERIOD_RST;
            width_r <= FPM_WIDTH_RST;
            wdev_req_r <= FPM_WDEV_RST;
            edge_r <= FPM_EDGE_RST;
            duty_r <= FPM_DUTY_RST;
            ddev_req_r <= FPM_DDEV_RST;
        end
        else if (wr)
        begin
            case (avs_address)
                FPM_REG_FSK_RATE: fsk_rate_r <= 32'(clamp({16'h0, wv},
                    {16'h0, FPM_FSK_RATE_MIN}, {16'h0, FPM_FSK_RATE_MAX}));
                FPM_REG_MOD_FREQ: mod_freq_r <= 32'(clamp({16'h0, wv},
                    {16'h0, FPM_MOD_FREQ_MIN}, {16'h0, FPM_MOD_FREQ_MAX}));
                FPM_REG_PERIOD: period_r <= clamp({16'h0, wv}, FPM_PERIOD_MIN, FPM_PERIOD_MAX);
                FPM_REG_WIDTH: width_r <= clamp({16'h0, wv}, 48'h0, period_r);
                FPM_REG_WDEV: wdev_req_r <= clamp({16'h0, wv}, 48'h0, FPM_WDEV_MAX);
                FPM_REG_EDGE: edge_r <= {16'h0, wv};
                FPM_REG_DUTY: duty_r <= 16'(clamp({16'h0, wv}, 48'h0,
                    {32'h0, FPM_DUTY_FULL}));
                FPM_REG_DDEV: ddev_req_r <= 16'(clamp({16'h0, wv}, 48'h0,
                    {32'h0, FPM_DUTY_FULL}));
                default: ;
            endcase
        end
    end

    // ****************************************
    // coupled deviation limits
    // ****************************************
    logic [47:0] wmin;
    logic [47:0] edge16;
    logic [47:0] guard;
    logic [47:0] wdev_lim;
    logic [47:0] wdev_eff;
    logic [47:0] room_hi;
    logic [47:0] dguard;
    logic [15:0] ddev_lim;
    logic [15:0] ddev_eff;
    logic [63:0] dg_num;
    always_comb
    begin
        if (period_r <= FPM_P_10S)
            wmin = FPM_WMIN_0;
        else if (period_r <= FPM_P_100S)
            wmin = FPM_WMIN_1;
        else if (period_r <= FPM_P_1000S)
            wmin = FPM_WMIN_2;
        else
            wmin = FPM_WMIN_3;
        // 1.6 times edge time, rounded up
        edge16 = (edge_r * 48'h10 + 48'h9) / 48'ha;
        guard = (edge16 > wmin) ? edge16 : wmin;
        room_hi = sat_sub(period_r, width_r);
        // never above width and the two margins
        wdev_lim = sat_sub(width_r, guard);
        if (sat_sub(room_hi, guard) < wdev_lim)
            wdev_lim = sat_sub(room_hi, guard);
        wdev_eff = (wdev_req_r < wdev_lim) ? wdev_req_r : wdev_lim;
        // guard in 0.01 percent units of period
        dg_num = {16'h0, guard} * 64'h2710 + {16'h0, period_r} - 64'h1;
        dguard = 48'(dg_num / {16'h0, period_r});
        if (dguard > {32'h0, FPM_DUTY_FULL})
            dguard = {32'h0, FPM_DUTY_FULL};
        ddev_lim = 16'(sat_sub({32'h0, duty_r}, dguard));
        if (16'(sat_sub({32'h0, FPM_DUTY_FULL - duty_r}, dguard)) < ddev_lim)
            ddev_lim = 16'(sat_sub({32'h0, FPM_DUTY_FULL - duty_r}, dguard));
        ddev_eff = (ddev_req_r < ddev_lim) ? ddev_req_r : ddev_lim;
    end

    // ****************************************
    // rate generators
    // ****************************************
    logic [31:0] fsk_acc_r;
    logic [31:0] mod_acc_r;
    logic [31:0] fsk_inc;
    logic [31:0] mod_inc;
    assign fsk_inc = 32'((64'(fsk_rate_r) << 32) / FPM_CLK_MILLIHZ);
    assign mod_inc = 32'((64'(mod_freq_r) << 32) / FPM_CLK_MILLIHZ);
    logic fsk_ext;
    assign fsk_ext = ctrl_r[FPM_B_FSK_EXT];
    always_ff @(posedge clock)
    begin
        if (srst)
            fsk_acc_r <= 32'h0;
        else if (!fsk_ext)
            fsk_acc_r <= fsk_acc_r + (fsk_inc == 32'h0 ? 32'h1 : fsk_inc);
    end
    always_ff @(posedge clock)
    begin
        if (srst)
            mod_acc_r <= 32'h0;
        else
            mod_acc_r <= mod_acc_r + (mod_inc == 32'h0 ? 32'h1 : mod_inc);
    end

    // noise source
    logic [15:0] lfsr_r;
    always_ff @(posedge clock)
    begin
        if (srst)
            lfsr_r <= 16'hace1;
        else
            lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end

    // ****************************************
    // modulating shape, signed 12 bit
    // ****************************************
    logic signed [11:0] shape_val;
    logic [11:0] ph;
    fpm_shape_e shape;
    assign shape = fpm_shape_e'(ctrl_r[FPM_B_SHAPE +: 3]);
    assign ph = mod_acc_r[31:20];
    always_comb
    begin
        case (shape)
            FPM_SQUARE: shape_val = ph[11] ? -12'sd2047 : 12'sd2047;
            // ramp full symmetry, negative ramp zero
            FPM_RAMP: shape_val = $signed(ph ^ 12'h800);
            FPM_NRAMP: shape_val = $signed(~ph ^ 12'h800);
            FPM_TRI: shape_val = $signed((ph[11] ? ~{ph[10:0], 1'b0} : {ph[10:0], 1'b0})
                ^ 12'h800);
            FPM_NOISE: shape_val = $signed(lfsr_r[11:0]);
            // sine approximated by the triangle, saves a table
            default: shape_val = $signed((ph[11] ? ~{ph[10:0], 1'b0} : {ph[10:0], 1'b0})
                ^ 12'h800);
        endcase
    end

    // arb table decimated onto 4K points
    logic [11:0] arb_addr_r;
    always_ff @(posedge clock)
    begin
        if (srst)
            arb_addr_r <= 12'h0;
        else
            arb_addr_r <= 12'(mod_acc_r[31:20] % FPM_ARB_PTS);
    end
    assign arb_addr = arb_addr_r;

    // ****************************************
    // pulse generator
    // ****************************************
    logic signed [11:0] mod_sel;
    logic [47:0] cnt_r;
    logic [47:0] period_cyc;
    logic [47:0] cur_width;
    logic signed [63:0] delta;
    logic pwm_on;
    assign pwm_on = ctrl_r[FPM_B_PWM_EN] & ctrl_r[FPM_B_PULSE]
        & ~ctrl_r[FPM_B_SWEEP] & ~ctrl_r[FPM_B_BURST];
    // external input replaces the internal shape
    assign mod_sel = ctrl_r[FPM_B_PWM_EXT] ? ext_mod : shape_val;
    assign period_cyc = (period_r / 48'h4 == 48'h0) ? 48'h1 : period_r / 48'h4;
    always_comb
    begin
        // linear scale, full scale 2047 is full deviation
        delta = (64'(signed'(mod_sel)) * 64'(signed'({16'h0, wdev_eff}))) / 64'sd2047;
        cur_width = pwm_on ? 48'(64'(signed'({16'h0, width_r})) + delta) : width_r;
    end
    always_ff @(posedge clock)
    begin
        if (srst)
            cnt_r <= 48'h0;
        else if (cnt_r + 48'h1 >= period_cyc)
            cnt_r <= 48'h0;
        else
            cnt_r <= cnt_r + 48'h1;
    end

    fpm_out_s out_r;
    always_ff @(posedge clock)
    begin
        if (srst)
            out_r <= '0;
        else
        begin
            out_r.hop <= ctrl_r[FPM_B_FSK_EN] & (fsk_ext ? trig_in : fsk_acc_r[31]);
            out_r.pwm_on <= pwm_on;
            out_r.pulse <= ctrl_r[FPM_B_PULSE] & ((cnt_r << 2) < cur_width);
        end
    end
    assign mod_out = out_r;

    // ****************************************
    // read back
    // ****************************************
    always_ff @(posedge clock)
    begin
        if (srst)
            avs_readdata <= 32'h0;
        else if (avs_read && !ack_r)
        begin
            case (avs_address)
                FPM_REG_CTRL: avs_readdata <= {16'h0, ctrl_r};
                FPM_REG_FSK_RATE: avs_readdata <= fsk_rate_r;
                FPM_REG_PERIOD: avs_readdata <= period_r[31:0];
                FPM_REG_WIDTH: avs_readdata <= width_r[31:0];
                FPM_REG_WDEV: avs_readdata <= wdev_eff[31:0];
                FPM_REG_EDGE: avs_readdata <= edge_r[31:0];
                FPM_REG_MOD_FREQ: avs_readdata <= mod_freq_r;
                FPM_REG_STATUS: avs_readdata <= {29'h0, out_r};
                FPM_REG_DUTY: avs_readdata <= {16'h0, duty_r};
                FPM_REG_DDEV: avs_readdata <= {16'h0, ddev_eff};
                default: avs_readdata <= 32'h0;
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_ext_sel;
        ctrl_r[FPM_B_FSK_EN] && fsk_ext;
    endsequence
    property p_ext_hop;
        @(posedge clock) disable iff (srst)
        s_ext_sel |=> (out_r.hop == $past(trig_in));
    endproperty
    a_ext_hop: assert property (p_ext_hop) else $error("hop does not follow trigger");
    property p_ext_frozen;
        @(posedge clock) disable iff (srst)
        fsk_ext |=> $stable(fsk_acc_r);
    endproperty
    a_ext_frozen: assert property (p_ext_frozen) else $error("rate runs under ext");
    property p_pwm_pulse;
        @(posedge clock) disable iff (srst)
        out_r.pwm_on |-> ctrl_r[FPM_B_PULSE] || $past(ctrl_r[FPM_B_PULSE]);
    endproperty
    a_pwm_pulse: assert property (p_pwm_pulse) else $error("pwm without pulse");
    property p_no_sweep;
        @(posedge clock) disable iff (srst)
        (ctrl_r[FPM_B_SWEEP] || ctrl_r[FPM_B_BURST]) |=> !out_r.pwm_on;
    endproperty
    a_no_sweep: assert property (p_no_sweep) else $error("pwm with sweep or burst");
    property p_wdev_width;
        @(posedge clock) disable iff (srst) wdev_eff <= width_r;
    endproperty
    a_wdev_width: assert property (p_wdev_width) else $error("wdev above width");
    property p_wdev_wmin;
        @(posedge clock) disable iff (srst)
        wdev_eff == 48'h0 || wdev_eff + wmin <= room_hi;
    endproperty
    a_wdev_wmin: assert property (p_wdev_wmin) else $error("wdev breaks wmin");
    property p_wdev_edge;
        @(posedge clock) disable iff (srst)
        wdev_eff == 48'h0 || wdev_eff + edge16 <= width_r;
    endproperty
    a_wdev_edge: assert property (p_wdev_edge) else $error("wdev breaks edge");
    property p_ddev_duty;
        @(posedge clock) disable iff (srst) ddev_eff <= duty_r;
    endproperty
    a_ddev_duty: assert property (p_ddev_duty) else $error("ddev above duty");
    property p_rate_range;
        @(posedge clock) disable iff (srst)
        fsk_rate_r >= FPM_FSK_RATE_MIN && fsk_rate_r <= FPM_FSK_RATE_MAX;
    endproperty
    a_rate_range: assert property (p_rate_range) else $error("fsk rate out of range");
    property p_period_range;
        @(posedge clock) disable iff (srst)
        period_r >= FPM_PERIOD_MIN && period_r <= FPM_PERIOD_MAX;
    endproperty
    a_period_range: assert property (p_period_range) else $error("period out of range");
endmodule

// ===== logic/fpm_pkg.sv
// package for the fsk / pwm modulation control block
// assumes one 250 MHz clock and a synchronous active-high reset
//
// Behaviour
// - internal fsk toggles carrier/hop at rate 2 mHz..100 kHz, default 10 Hz; the code runs no slower than about 58 mHz
// - external fsk source ignores the programmed internal rate
// - fsk source is internal or external, internal after reset
// - external fsk: trigger low gives carrier, trigger high gives hop
// - trigger polarity is fixed when used for fsk
// - pwm only with the pulse waveform; pwm is pulse's only modulation
// - pwm never active together with sweep or burst
// - pulse period 200 ns..2000 s, default 1 ms; the code takes 32-bit writes, so at most about 4.29 s
// - shape sine default, square, ramp, neg ramp, triangle, noise, arb; the code gives the triangle for sine and arb
// - arbitrary modulating shape decimated to at most 4K points
// - pwm modulating frequency 2 mHz..20 kHz, default 10 Hz; the code runs no slower than about 58 mHz
// - width deviation 0..1000 s, default 10 us, never above width; the code takes 32-bit writes, so at most about 4.29 s
// - width deviation limited by width and period minus width, less wmin
// - width deviation limited by width and period minus width, less 1.6 edge
// - duty deviation 0..100 percent, default 1, never above duty
// - duty deviation limited by duty terms less 100 wmin over period
// - duty deviation limited by duty terms less 160 edge over period
// - pwm source internal or external, internal after reset
// - external input scales deviation linearly, +-5 v gives +-full deviation
package fpm_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] FPM_REG_CTRL = 4'h0;
    localparam logic [3:0] FPM_REG_FSK_RATE = 4'h1;
    localparam logic [3:0] FPM_REG_PERIOD = 4'h2;
    localparam logic [3:0] FPM_REG_WIDTH = 4'h3;
    localparam logic [3:0] FPM_REG_WDEV = 4'h4;
    localparam logic [3:0] FPM_REG_EDGE = 4'h5;
    localparam logic [3:0] FPM_REG_MOD_FREQ = 4'h6;
    localparam logic [3:0] FPM_REG_STATUS = 4'h7;
    localparam logic [3:0] FPM_REG_DUTY = 4'h8;
    localparam logic [3:0] FPM_REG_DDEV = 4'h9;
    // ctrl bit positions
    localparam int FPM_B_FSK_EN = 0;
    localparam int FPM_B_FSK_EXT = 1;
    localparam int FPM_B_PWM_EN = 2;
    localparam int FPM_B_PULSE = 3;
    localparam int FPM_B_SWEEP = 4;
    localparam int FPM_B_BURST = 5;
    localparam int FPM_B_PWM_EXT = 6;
    localparam int FPM_B_SHAPE = 8;
    // ****************************************
    // units: rates in mHz, times in ns, duty in 0.01 percent
    // ****************************************
    localparam logic [31:0] FPM_FSK_RATE_MIN = 32'h0000_0002;
    localparam logic [31:0] FPM_FSK_RATE_MAX = 32'h05f5_e100;
    localparam logic [31:0] FPM_FSK_RATE_RST = 32'h0000_2710;
    localparam logic [31:0] FPM_MOD_FREQ_MIN = 32'h0000_0002;
    localparam logic [31:0] FPM_MOD_FREQ_MAX = 32'h0131_2d00;
    localparam logic [31:0] FPM_MOD_FREQ_RST = 32'h0000_2710;
    localparam logic [47:0] FPM_PERIOD_MIN = 48'h0000_0000_00c8;
    localparam logic [47:0] FPM_PERIOD_MAX = 48'h01d1_a94a_2000;
    localparam logic [47:0] FPM_PERIOD_RST = 48'h0000_000f_4240;
    localparam logic [47:0] FPM_WIDTH_RST = 48'h0000_0007_a120;
    localparam logic [47:0] FPM_WDEV_MAX = 48'h00e8_d4a5_1000;
    localparam logic [47:0] FPM_WDEV_RST = 48'h0000_0000_2710;
    localparam logic [47:0] FPM_EDGE_RST = 48'h0000_0000_0005;
    localparam logic [15:0] FPM_DUTY_FULL = 16'h2710;
    localparam logic [15:0] FPM_DUTY_RST = 16'h1388;
    localparam logic [15:0] FPM_DDEV_RST = 16'h0064;
    // wmin thresholds and values
    localparam logic [47:0] FPM_P_10S = 48'h0002_540b_e400;
    localparam logic [47:0] FPM_P_100S = 48'h0017_4876_e800;
    localparam logic [47:0] FPM_P_1000S = 48'h00e8_d4a5_1000;
    localparam logic [47:0] FPM_WMIN_0 = 48'h0000_0000_0014;
    localparam logic [47:0] FPM_WMIN_1 = 48'h0000_0000_00c8;
    localparam logic [47:0] FPM_WMIN_2 = 48'h0000_0000_07d0;
    localparam logic [47:0] FPM_WMIN_3 = 48'h0000_0000_4e20;
    localparam int FPM_ARB_PTS = 4096;
    localparam int FPM_CLK_MHZ = 250;
    // phase accumulators: increment = rate_mhz * 2^32 / (250e6 * 1000)
    localparam logic [63:0] FPM_CLK_MILLIHZ = 64'h0000_0000_3b9a_ca00 * 64'hfa;

    typedef enum logic [2:0]
    {
        FPM_SINE = 3'b000,
        FPM_SQUARE = 3'b001,
        FPM_RAMP = 3'b010,
        FPM_NRAMP = 3'b011,
        FPM_TRI = 3'b100,
        FPM_NOISE = 3'b101,
        FPM_ARB = 3'b110
    } fpm_shape_e;

    typedef struct packed
    {
        logic hop;
        logic pwm_on;
        logic pulse;
    } fpm_out_s;
endpackage
